// [include/pss_params.svh]
// Command codes, field positions, reset values and timing for the status bank
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

// ************************************************************
// Command codes
// ************************************************************
`define PSS_CMD_FALL_TIME   8'h65
`define PSS_CMD_SUM_BYTE    8'h78
`define PSS_CMD_SUM_WORD    8'h79
`define PSS_CMD_VOUT_STAT   8'h7A
`define PSS_CMD_VOUT_MASK   8'hD8
`define PSS_CMD_EXT_MASK    8'hD9

// ************************************************************
// Field positions
// ************************************************************
`define PSS_EXP_MSB         15
`define PSS_EXP_LSB         11
`define PSS_MAN_MSB         10
`define PSS_BUSY_BIT        7
`define PSS_VOUT_FLAG_MSB   7
`define PSS_VOUT_FLAG_LSB   2
`define PSS_OVF_BIT         7

// ************************************************************
// Reset values and limits
// ************************************************************
`define PSS_FALL_EXP        5'h1E
`define PSS_FALL_MAN_RESET  11'h004
`define PSS_FALL_MAN_MIN    11'h002
`define PSS_FALL_MAN_MAX    11'h07F
`define PSS_MASK_RESET      8'h00
`define PSS_EXT_MASK_RESET  3'h0

// ************************************************************
// Timing
// ************************************************************
`define PSS_FALL_LSB_US     250
`define PSS_CLK_MHZ         50
`define PSS_STEP_CYCLES     (`PSS_FALL_LSB_US * `PSS_CLK_MHZ)

`endif

// [include/pss_pkg.sv]
// Types shared by the status bank, its host model, properties and testbench
package pss_pkg;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        word;
		logic [7:0]  cmd;
		logic [15:0] wdata;
	} pss_req_type;

	typedef struct packed {
		logic ov_fault;
		logic ov_warn;
		logic uv_warn;
		logic uv_fault;
		logic min_max;
		logic startup_timeout;
	} pss_vout_evt_type;

	typedef struct packed {
		logic fixed_ov;
		logic tracking_ov;
		logic prebias_ov;
	} pss_ov_src_type;

	typedef struct packed {
		logic summary_output_overcurrent;
		logic iout_any;
		logic summary_input_undervoltage;
		logic input_any;
		logic temp_any;
		logic cml_any;
		logic mfr_any;
		logic other_any;
	} pss_summary_type;

	typedef enum logic [1:0] {
		RAMP_IDLE = 2'b01,
		RAMP_RUN  = 2'b10
	} pss_ramp_state_type;

endpackage

// [rtl/pss_status_regs.sv]
// Soft-off fall time, fault summary and output-voltage status registers
//
// Summary of operation
// [R1] Fall time word, exponent fixed at -2
// [R2] Fall 0.5 to 31.75 ms, minimum 0.5
// [R3] Fall writes above 31.75 ms or off-format flagged invalid data
// [R4] Reference ramps to zero over fall time
// [R5] Status byte equals status word low byte
// [R6] Summary bits only follow detail registers
// [R7] Busy bit sets on busy fault, 80h clears
// [R8] Bit 6 live: not converting power
// [R9] Status byte category bits 5 to 0
// [R10] Status word high byte category bits
// [R11] Word bit 11 follows power-good pin
// [R12] Word writes 0080h/0180h clear busy
// [R13] Output-voltage flags latch from zero reset
// [R14] Flags clear by clear-faults or write-1
// [R15] Each alerting bit has own mask
// [R16] Extended mask splits three overvoltage sources
// [R17] Category bit ORs latched detail flags
// [R18] Read-only bits ignore writes, read zero
`include "pss_params.svh"
`timescale 1ns/1ps

module pss_status_regs #(
	parameter int P_STEP_CYCLES = `PSS_STEP_CYCLES
) (
	input  wire logic                     I_CORE_CLK,
	input  wire logic                     I_RESETN,
	input  wire pss_pkg::pss_req_type     I_REG_REQ,
	output logic [15:0]                   O_REG_RDATA,
	output logic                          O_REG_ACK,
	output logic                          O_REG_UNSUPPORTED,
	output logic                          O_INVALID_DATA,
	input  wire logic                     I_CLEAR_FAULTS,
	input  wire logic                     I_BUSY_FAULT,
	input  wire logic                     I_CONVERTING,
	input  wire logic                     I_POWER_GOOD_PIN,
	input  wire pss_pkg::pss_vout_evt_type I_VOUT_EVT,
	input  wire pss_pkg::pss_ov_src_type  I_OV_SRC,
	input  wire pss_pkg::pss_summary_type I_SUMMARY,
	input  wire logic                     I_SOFT_OFF_START,
	input  wire logic [11:0]              I_VREF_START,
	output logic [11:0]                   O_VREF,
	output logic                          O_RAMP_ACTIVE,
	output logic                          O_RAMP_DONE,
	output logic                          O_ALERT
);
	import pss_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [10:0]        fall_man_reg;
	logic               busy_reg;
	logic [5:0]         vout_flag_reg;
	logic [5:0]         vout_flag_next;
	pss_ov_src_type     ov_src_reg;
	pss_ov_src_type     ov_src_next;
	logic [7:0]         vout_mask_reg;
	logic               busy_mask_reg;
	logic [2:0]         ext_mask_reg;
	logic [15:0]        rdata_reg;
	logic               ack_reg;
	logic               unsup_reg;
	logic               invalid_reg;
	logic               power_good_live_sync;
	logic               wr_fall;
	logic               wr_byte;
	logic               wr_word;
	logic               wr_vout;
	logic               wr_vmask;
	logic               wr_emask;
	logic               known_cmd;
	logic               fall_valid;
	logic [7:0]         status_byte;
	logic [15:0]        status_word;
	logic [7:0]         vout_status;
	pss_ramp_state_type ramp_state_reg;
	logic [11:0]        vref_reg;
	logic [11:0]        ramp_start_reg;
	logic [21:0]        ramp_total_reg;
	logic [21:0]        ramp_cnt_reg;
	logic [21:0]        ramp_acc_reg;
	logic [21:0]        acc_sum;
	logic               ramp_done_reg;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [6:0] eff_mantissa(input logic [10:0] man);
		if (man < `PSS_FALL_MAN_MIN)
			eff_mantissa = 7'(`PSS_FALL_MAN_MIN);  // [R2]
		else
			eff_mantissa = man[6:0];
	endfunction

	function automatic logic [21:0] fall_cycles(input logic [10:0] man);
		fall_cycles = 22'(eff_mantissa(man) * P_STEP_CYCLES);
	endfunction

	// Bit 10 set would make the mantissa negative
	function automatic logic fall_word_ok(input logic [15:0] w);
		fall_word_ok = (w[`PSS_EXP_MSB:`PSS_EXP_LSB] == `PSS_FALL_EXP) &&  // [R1]
		               !w[`PSS_MAN_MSB] &&
		               (w[`PSS_MAN_MSB:0] <= `PSS_FALL_MAN_MAX);            // [R3]
	endfunction

	// ************************************************************
	// Pin input
	// ************************************************************
	pss_sync u_power_good_live_sync (
		.i_clk    (I_CORE_CLK),
		.i_resetn (I_RESETN),
		.i_async  (I_POWER_GOOD_PIN),
		.o_sync   (power_good_live_sync)
	);

	// ************************************************************
	// Command decode
	// ************************************************************
	assign wr_fall  = I_REG_REQ.wr && (I_REG_REQ.cmd == `PSS_CMD_FALL_TIME);
	assign wr_byte  = I_REG_REQ.wr && (I_REG_REQ.cmd == `PSS_CMD_SUM_BYTE);
	assign wr_word  = I_REG_REQ.wr && (I_REG_REQ.cmd == `PSS_CMD_SUM_WORD);
	assign wr_vout  = I_REG_REQ.wr && (I_REG_REQ.cmd == `PSS_CMD_VOUT_STAT);
	assign wr_vmask = I_REG_REQ.wr && (I_REG_REQ.cmd == `PSS_CMD_VOUT_MASK);
	assign wr_emask = I_REG_REQ.wr && (I_REG_REQ.cmd == `PSS_CMD_EXT_MASK);

	assign known_cmd = (I_REG_REQ.cmd == `PSS_CMD_FALL_TIME) ||
	                   (I_REG_REQ.cmd == `PSS_CMD_SUM_BYTE) ||
	                   (I_REG_REQ.cmd == `PSS_CMD_SUM_WORD) ||
	                   (I_REG_REQ.cmd == `PSS_CMD_VOUT_STAT) ||
	                   (I_REG_REQ.cmd == `PSS_CMD_VOUT_MASK) ||
	                   (I_REG_REQ.cmd == `PSS_CMD_EXT_MASK);

	assign fall_valid = fall_word_ok(I_REG_REQ.wdata);

	// ************************************************************
	// Fall time register
	// ************************************************************
	// Rejected words leave the previous setting in force
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			fall_man_reg <= `PSS_FALL_MAN_RESET;
		end else if (wr_fall && fall_valid) begin
			fall_man_reg <= I_REG_REQ.wdata[`PSS_MAN_MSB:0];  // [R1] [R2]
		end
	end

	// ************************************************************
	// Busy bit
	// ************************************************************
	// A new busy fault wins over a clear in the same cycle
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			busy_reg <= 1'b0;
		end else if (I_BUSY_FAULT) begin
			busy_reg <= 1'b1;  // [R7]
		end else if (I_CLEAR_FAULTS) begin
			busy_reg <= 1'b0;
		end else if ((wr_byte || wr_word) && I_REG_REQ.wdata[`PSS_BUSY_BIT]) begin
			busy_reg <= 1'b0;  // [R7] [R12]
		end
	end

	// ************************************************************
	// Output-voltage status flags
	// ************************************************************
	always_comb begin
		vout_flag_next = vout_flag_reg;
		ov_src_next    = ov_src_reg;
		if (I_CLEAR_FAULTS) begin
			vout_flag_next = 6'h00;  // [R14]
			ov_src_next    = '0;
		end else if (wr_vout) begin
			vout_flag_next = vout_flag_reg &
			    ~I_REG_REQ.wdata[`PSS_VOUT_FLAG_MSB:`PSS_VOUT_FLAG_LSB];  // [R14] [R6]
			if (I_REG_REQ.wdata[`PSS_OVF_BIT])
				ov_src_next = '0;
		end
		// Set after clear so a coincident event is kept
		vout_flag_next = vout_flag_next | 6'(I_VOUT_EVT);  // [R13]
		ov_src_next    = ov_src_next | I_OV_SRC;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			vout_flag_reg <= 6'h00;  // [R13]
			ov_src_reg    <= '0;
		end else begin
			vout_flag_reg <= vout_flag_next;
			ov_src_reg    <= ov_src_next;
		end
	end

	// ************************************************************
	// Alert masks
	// ************************************************************
	// Busy mask rides at bit 8 of the vout mask word
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			vout_mask_reg <= `PSS_MASK_RESET;
			busy_mask_reg <= 1'b0;
		end else if (wr_vmask) begin
			vout_mask_reg <= {I_REG_REQ.wdata[7:2], 2'b00};  // [R15] [R18]
			busy_mask_reg <= I_REG_REQ.wdata[8];
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			ext_mask_reg <= `PSS_EXT_MASK_RESET;
		end else if (wr_emask) begin
			ext_mask_reg <= I_REG_REQ.wdata[2:0];  // [R16]
		end
	end

	// ************************************************************
	// Summary composition
	// ************************************************************
	assign vout_status = {vout_flag_reg, 2'b00};  // [R13] [R18]

	assign status_byte = {
		busy_reg,                                     // [R7]
		~I_CONVERTING,                                // [R8]
		vout_flag_reg[5],                             // [R9] [R6]
		I_SUMMARY.summary_output_overcurrent,                            // [R9]
		I_SUMMARY.summary_input_undervoltage,
		I_SUMMARY.temp_any,
		I_SUMMARY.cml_any,
		vout_flag_reg[0] | I_SUMMARY.other_any        // [R17]
	};

	assign status_word = {
		|vout_flag_reg,                               // [R10] [R17]
		I_SUMMARY.iout_any,
		I_SUMMARY.input_any,
		I_SUMMARY.mfr_any,
		power_good_live_sync,                                   // [R11]
		1'b0,                                         // [R10] [R18]
		I_SUMMARY.other_any,
		1'b0,
		status_byte                                   // [R5]
	};

	// OV flag alerts only if a still-unmasked source raised it
	assign O_ALERT = (busy_reg & ~busy_mask_reg) |
	                 (|(vout_flag_reg[4:0] & ~vout_mask_reg[6:2])) |  // [R15]
	                 (vout_flag_reg[5] & ~vout_mask_reg[7] &
	                  (|(ov_src_reg & ~ext_mask_reg)));              // [R16]

	// ************************************************************
	// Read port and answers
	// ************************************************************
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rdata_reg <= 16'h0000;
		end else if (I_REG_REQ.rd) begin
			case (I_REG_REQ.cmd)
				`PSS_CMD_FALL_TIME: rdata_reg <= {`PSS_FALL_EXP, fall_man_reg};
				`PSS_CMD_SUM_BYTE:  rdata_reg <= {8'h00, status_byte};  // [R5]
				`PSS_CMD_SUM_WORD:  rdata_reg <= status_word;
				`PSS_CMD_VOUT_STAT: rdata_reg <= {8'h00, vout_status};
				`PSS_CMD_VOUT_MASK: rdata_reg <= {7'h00, busy_mask_reg, vout_mask_reg};
				`PSS_CMD_EXT_MASK:  rdata_reg <= {13'h0000, ext_mask_reg};
				default:            rdata_reg <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			ack_reg     <= 1'b0;
			unsup_reg   <= 1'b0;
			invalid_reg <= 1'b0;
		end else begin
			ack_reg     <= I_REG_REQ.wr | I_REG_REQ.rd;
			unsup_reg   <= (I_REG_REQ.wr | I_REG_REQ.rd) & ~known_cmd;
			invalid_reg <= wr_fall & ~fall_valid;  // [R3]
		end
	end

	assign O_REG_RDATA       = rdata_reg;
	assign O_REG_ACK         = ack_reg;
	assign O_REG_UNSUPPORTED = unsup_reg;
	assign O_INVALID_DATA    = invalid_reg;

	// ************************************************************
	// Soft-off reference ramp
	// ************************************************************
	// Start codes above the fall cycle count would need bigger steps
	// Accumulator steps the code down evenly so the ramp length
	// depends only on the fall time, never on the start code.
	// Codes stay below the minimum cycle count, so one step a cycle suffices.
	assign acc_sum = ramp_acc_reg + 22'(ramp_start_reg);

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			ramp_state_reg <= RAMP_IDLE;
			vref_reg       <= 12'h000;
			ramp_start_reg <= 12'h000;
			ramp_total_reg <= 22'h000000;
			ramp_cnt_reg   <= 22'h000000;
			ramp_acc_reg   <= 22'h000000;
			ramp_done_reg  <= 1'b0;
		end else begin
			ramp_done_reg <= 1'b0;
			case (ramp_state_reg)
				RAMP_IDLE: begin
					if (I_SOFT_OFF_START) begin
						vref_reg       <= I_VREF_START;
						ramp_start_reg <= I_VREF_START;
						ramp_total_reg <= fall_cycles(fall_man_reg);  // [R4]
						ramp_cnt_reg   <= 22'h000000;
						ramp_acc_reg   <= 22'h000000;
						ramp_state_reg <= RAMP_RUN;
					end
				end
				RAMP_RUN: begin
					ramp_cnt_reg <= ramp_cnt_reg + 22'h000001;
					if (ramp_cnt_reg == ramp_total_reg - 22'h000001) begin
						vref_reg       <= 12'h000;  // [R4]
						ramp_done_reg  <= 1'b1;
						ramp_state_reg <= RAMP_IDLE;
					end else if (acc_sum >= ramp_total_reg) begin
						ramp_acc_reg <= acc_sum - ramp_total_reg;
						vref_reg     <= vref_reg - 12'h001;  // [R4]
					end else begin
						ramp_acc_reg <= acc_sum;
					end
				end
				default: begin
					ramp_state_reg <= RAMP_IDLE;
				end
			endcase
		end
	end

	assign O_VREF        = vref_reg;
	assign O_RAMP_ACTIVE = (ramp_state_reg == RAMP_RUN);
	assign O_RAMP_DONE   = ramp_done_reg;
endmodule

// [rtl/pss_sync.sv]
// Two-flop level synchroniser for pin inputs
`timescale 1ns/1ps

module pss_sync (
	input  wire logic i_clk,
	input  wire logic i_resetn,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_reg;
	logic sync_reg;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;
endmodule

// [sim/pss_host_model.sv]
// Host model issuing one-cycle register requests
`timescale 1ns/1ps
module pss_host_model (
	input  wire logic            i_clk,
	input  wire logic            i_ack,
	input  wire logic [15:0]     i_rdata,
	input  wire logic            i_flag,
	output pss_pkg::pss_req_type o_req
);
	import pss_pkg::*;
	initial o_req = '0;
	// Write-1 clears go to the detail register, and to the status byte or word for busy
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] r, output logic f);
		@(negedge i_clk);
		o_req = '{w, ~w, 1'b1, c, d};
		// Answer stands only in the cycle after the taking edge
		@(negedge i_clk);
		r = (i_ack === 1'b1) ? i_rdata : 'x;
		f = i_flag;
		o_req = '0;
	endtask
endmodule

// [sim/pss_status_regs_properties.sv]
// Port-level checks for the status register bank
`timescale 1ns/1ps
module pss_status_regs_properties #(
	parameter int P_STEP_CYCLES = 12500
) (
	input wire logic                     I_CORE_CLK,
	input wire logic                     I_RESETN,
	input wire pss_pkg::pss_req_type     I_REG_REQ,
	input wire logic [15:0]              O_REG_RDATA,
	input wire logic                     O_REG_UNSUPPORTED,
	input wire logic                     O_INVALID_DATA,
	input wire logic                     I_CONVERTING,
	input wire pss_pkg::pss_summary_type I_SUMMARY,
	input wire logic [11:0]              O_VREF,
	input wire logic                     O_RAMP_ACTIVE,
	input wire logic                     O_RAMP_DONE
);
	import pss_pkg::*;
	// ********************
	// Helpers
	// ********************
	wire       rd = I_REG_REQ.rd;
	wire [7:0] c  = I_REG_REQ.cmd;
	wire       wf = I_REG_REQ.wr && c == 8'h65;
	wire       ok = I_REG_REQ.wdata[15:11] == 5'h1E && I_REG_REQ.wdata[10:0] <= 11'h07F;
	wire       kn = c inside {8'h65, 8'h78, 8'h79, 8'h7A, 8'hD8, 8'hD9};
	wire [3:0] sm = {I_SUMMARY.summary_output_overcurrent, I_SUMMARY.summary_input_undervoltage, I_SUMMARY.temp_any, I_SUMMARY.cml_any};
	int        act_cnt;
	// Ramp length counter, zeroed between ramps
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN)
			act_cnt <= 0;
		else
			act_cnt <= O_RAMP_ACTIVE ? act_cnt + 1 : 0;
	end
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESETN);
	// ********************
	// Assertions
	// ********************
	fall_reject_a: assert property (wf && !ok |=> O_INVALID_DATA)
		else $error("bad fall time not flagged");
	fall_accept_a: assert property (wf && ok |=> !O_INVALID_DATA)
		else $error("good fall time flagged");
	byte_high_a: assert property (rd && c == 8'h78 |=> O_REG_RDATA[15:8] == 8'h00)
		else $error("byte read upper not zero");
	off_live_a:
		assert property (rd && c == 8'h78 |=> O_REG_RDATA[6] == !$past(I_CONVERTING))
		else $error("off bit not live");
	byte_map_a: assert property (rd && c == 8'h78 |=> O_REG_RDATA[4:1] == $past(sm))
		else $error("summary bits misplaced");
	word_zero_a: assert property (rd && c == 8'h79 |=> !O_REG_RDATA[10] && !O_REG_RDATA[8])
		else $error("reserved word bit set");
	vout_low_a: assert property (rd && c == 8'h7A |=> O_REG_RDATA[1:0] == 2'b00)
		else $error("vout low bits set");
	unsup_zero_a:
		assert property (rd && !kn |=> O_REG_UNSUPPORTED && O_REG_RDATA == 16'h0000)
		else $error("unknown read not refused");
	ramp_end_a: assert property (O_RAMP_DONE |-> O_VREF == 12'h000 ##1 !O_RAMP_ACTIVE)
		else $error("ramp end wrong");
	ramp_slew_a:
		assert property (O_RAMP_ACTIVE && $past(O_RAMP_ACTIVE) |-> $past(O_VREF) - O_VREF <= 12'h001)
		else $error("ramp step too large");
	ramp_len_a:
		assert property (O_RAMP_DONE |-> act_cnt >= 2 * P_STEP_CYCLES - 2 && act_cnt <= 127 * P_STEP_CYCLES)
		else $error("ramp length out of range");
	cover property (wf && !ok);
	cover property (O_RAMP_DONE);
	cover property (rd && !kn);
endmodule

bind pss_status_regs pss_status_regs_properties #(.P_STEP_CYCLES(P_STEP_CYCLES))
	i_pss_status_regs_properties (.*);

// [sim/pss_status_regs_tb.sv]
// Self-checking bench for the status register bank
`timescale 1ns/1ps
module pss_status_regs_tb;
	import pss_pkg::*;
	typedef struct packed {logic w; logic [7:0] c; logic [15:0] d; logic [15:0] e; logic f;} pss_row_type;
	localparam int STEP = 10;
	logic             clk = 1'b0, rstn = 1'b0, clr = 1'b0, busy = 1'b0;
	logic             conv = 1'b1, pg = 1'b0, start = 1'b0;
	pss_req_type      req;
	pss_vout_evt_type evt = '0;
	pss_ov_src_type   src = '0;
	pss_summary_type  sum = '0;
	logic [15:0]      rdata, rd;
	logic [11:0]      vref;
	logic [11:0]      vstart = 12'h00F;
	logic             ack, unsup, inv, done, alert, fl;
	int               error_cnt = 0, n_checks = 0, cyc = 0, n;
	pss_row_type rows [13] = '{
		'{1'b0, 8'h65, 16'h0000, 16'hF004, 1'b0}, '{1'b0, 8'h7A, 16'h0000, 16'h0000, 1'b0},
		'{1'b0, 8'h78, 16'h0000, 16'h0000, 1'b0}, '{1'b0, 8'h79, 16'h0000, 16'h0000, 1'b0},
		'{1'b1, 8'h65, 16'hF07F, 16'h0000, 1'b0}, '{1'b1, 8'h65, 16'hF080, 16'h0000, 1'b1},
		'{1'b1, 8'h65, 16'hF800, 16'h0000, 1'b1}, '{1'b1, 8'h65, 16'hF402, 16'h0000, 1'b1},
		'{1'b0, 8'h65, 16'h0000, 16'hF07F, 1'b0}, '{1'b1, 8'h7A, 16'h0003, 16'h0000, 1'b0},
		'{1'b1, 8'h79, 16'hFF7F, 16'h0000, 1'b0}, '{1'b0, 8'h7A, 16'h0000, 16'h0000, 1'b0},
		'{1'b0, 8'h99, 16'h0000, 16'h0000, 1'b1}};
	always #10 clk = ~clk;
	pss_status_regs #(.P_STEP_CYCLES(STEP)) i_pss_status_regs (
		.I_CORE_CLK(clk), .I_RESETN(rstn), .I_REG_REQ(req), .O_REG_RDATA(rdata),
		.O_REG_ACK(ack), .O_REG_UNSUPPORTED(unsup), .O_INVALID_DATA(inv),
		.I_CLEAR_FAULTS(clr), .I_BUSY_FAULT(busy), .I_CONVERTING(conv),
		.I_POWER_GOOD_PIN(pg), .I_VOUT_EVT(evt), .I_OV_SRC(src), .I_SUMMARY(sum),
		.I_SOFT_OFF_START(start), .I_VREF_START(vstart), .O_VREF(vref),
		.O_RAMP_ACTIVE(), .O_RAMP_DONE(done), .O_ALERT(alert));
	pss_host_model i_pss_host_model (
		.i_clk(clk), .i_ack(ack), .i_rdata(rdata), .i_flag(inv | unsup), .o_req(req));
	// ********************
	// Tasks
	// ********************
	task automatic stop_test;
		$display("errors %0d checks %0d", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d);
		i_pss_host_model.xfer(w, c, d, rd, fl);
	endtask
	// Single-cycle strobes, driven on the falling edge
	task automatic pulse(input logic [5:0] e, input logic [2:0] s, input logic cf, input logic bf);
		@(negedge clk);
		evt = e;
		src = s;
		clr = cf;
		busy = bf;
		@(negedge clk);
		{evt, src, clr, busy} = '0;
	endtask
	// Hang guard: the whole run needs far fewer cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			$display("[FAIL] %0t timeout", $time);
			stop_test();
		end
	end
	// ********************
	// Sequence
	// ********************
	initial begin
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		foreach (rows[k]) begin
			op(rows[k].w, rows[k].c, rows[k].d);
			if (!rows[k].w)
				check(rd, rows[k].e);
			check(fl, rows[k].f);
		end
		pulse(6'h3F, 3'h4, 1'b0, 1'b0);
		op(0, 8'h7A, 0);
		check(rd, 16'h00FC);
		op(0, 8'h79, 0);
		check(rd, 16'h8021);
		check(alert, 1'b1);
		op(1, 8'h7A, 16'h0000);
		op(0, 8'h7A, 0);
		check(rd, 16'h00FC);
		op(1, 8'h7A, 16'h0080);
		op(0, 8'h78, 0);
		check(rd, 16'h0001);
		pulse(0, 0, 1'b1, 1'b0);
		op(0, 8'h7A, 0);
		check(rd, 16'h0000);
		check(alert, 1'b0);
		op(1, 8'hD8, 16'h0080);
		pulse(6'h20, 3'h4, 1'b0, 1'b0);
		check(alert, 1'b0);
		op(1, 8'hD8, 0);
		op(1, 8'hD9, 16'h0004);
		check(alert, 1'b0);
		op(1, 8'hD9, 16'h0002);
		check(alert, 1'b1);
		pulse(0, 0, 1'b1, 1'b0);
		for (int k = 0; k < 3; k++) begin
			pulse(0, 0, 1'b0, 1'b1);
			op(0, 8'h78, 0);
			check(rd, 16'h0080);
			op(1, (k == 0) ? 8'h78 : 8'h79, (k == 2) ? 16'h0180 : 16'h0080);
			op(0, 8'h79, 0);
			check(rd, 16'h0000);
		end
		@(negedge clk);
		{conv, pg, sum} = {1'b0, 1'b1, 8'hFF};
		repeat (3) @(negedge clk);
		op(0, 8'h79, 0);
		check(rd, 16'h7A5F);
		@(negedge clk);
		{conv, pg, sum} = {1'b1, 1'b0, 8'h00};
		// Mantissa 1 must run as the 0.5 ms floor
		for (int k = 0; k < 2; k++) begin
			op(1, 8'h65, k ? 16'hF004 : 16'hF001);
			@(negedge clk);
			start = 1'b1;
			vstart = k ? 12'h00F : 12'h013;
			@(negedge clk);
			start = 1'b0;
			n = 0;
			while (done !== 1'b1 && n < 500) begin
				@(posedge clk);
				#1;
				n++;
			end
			check(16'(n), k ? 16'd40 : 16'd20);
			check(vref, 12'h000);
		end
		op(1, 8'h65, 16'hF010);
		pulse(0, 0, 1'b0, 1'b1);
		rstn = 1'b0;
		@(negedge clk);
		rstn = 1'b1;
		op(0, 8'h65, 0);
		check(rd, 16'hF004);
		op(0, 8'h78, 0);
		check(rd, 16'h0000);
		stop_test();
	end
endmodule
